// file: logic/dcp_pkg.sv
// Purpose: constants and types for the colour and palette register bank
// Assumes: byte-addressed register port, byte offsets as printed
// Notes: offsets are relative to the controller base address
package dcp_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam logic [15:0] OFF_CURSOR_COLOR = 16'h8360;
	localparam logic [15:0] OFF_RSVD_COLOR = 16'h8364;
	localparam logic [15:0] OFF_BORDER_COLOR = 16'h8368;
	localparam logic [15:0] OFF_PAL_INDEX = 16'h8370;
	localparam logic [15:0] OFF_PAL_DATA = 16'h8374;
	localparam logic [15:0] OFF_DFIFO_TEST = 16'h8378;
	localparam logic [15:0] OFF_CFIFO_TEST = 16'h837c;
	localparam logic [15:0] OFF_DISP_MODE = 16'h8380;
	localparam logic [15:0] CURSOR_RESET = 16'h0000;
	localparam logic [7:0] BORDER_RESET = 8'h00;
	localparam logic [8:0] PAL_INDEX_RESET = 9'h000;
	localparam logic [8:0] PAL_CURSOR0 = 9'h100;
	localparam logic [8:0] PAL_CURSOR1 = 9'h101;
	localparam logic [8:0] PAL_OVERSCAN = 9'h104;
	localparam int unsigned PAL_ENTRIES = 261;
	localparam int unsigned DFIFO_WORDS = 16;
	localparam int unsigned CFIFO_WORDS = 16;
	localparam int unsigned FIFO_AW = 4;
	localparam logic [17:0] ENTRY_RESET = 18'h00000;
	localparam int unsigned MODE_8BPP_BIT = 0;
	localparam int unsigned MODE_EXTDAC_BIT = 1;
	localparam int unsigned MODE_PANEL_BIT = 2;
	localparam int unsigned TEST_DATA_W = 16;
	localparam int unsigned TEST_ADDR_LSB = 16;

	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dcp_req_t;

	typedef struct packed {
		logic [7:0] cursor_first;
		logic [7:0] cursor_second;
		logic [7:0] border;
	} dcp_dac_idx_t;

	typedef struct packed {
		logic [17:0] cursor_first;
		logic [17:0] cursor_second;
		logic [17:0] overscan;
	} dcp_panel_col_t;
endpackage

// file: logic/dcp_regs.sv
// Purpose: colour index, palette access and ram test registers
// Assumes: one clock, strobes synchronous, read data one cycle later
// Notes: palette extension entries feed the flat panel path
// Summary of operation
// R1: in 8 bpp with external converter, output cursor and border indices.
// R2: flat panel path takes cursor and border colours from palette extensions.
// R3: cursor register holds colour one index at 15:8, zero at 7:0.
// R4: software points cursor indices at reserved or static palette entries.
// R5: software writes zero to unused upper register bits.
// R6: word between cursor and border registers reads as zero.
// R7: border register is read-only and shows the 8-bit border index.
// R8: palette holds 256 standard entries plus cursor and overscan extensions.
// R9: software loads the palette index before touching the data register.
// R10: two diagnostic registers test display fifo and line buffer rams.
// R11: each palette data read or write advances the index by one.
// R12: palette data register carries one 18-bit entry in bits 17:0.
// R13: 0-ffh standard, 100h/101h cursor, 104h overscan, others invalid.
// R14: palette writes keep the previous output colour, no sparkle.
// R15: palette data read returns stored entry, upper bits zero.
module dcp_regs
	import dcp_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire dcp_pkg::dcp_req_t req,
	output logic [31:0] rdata,
	input wire logic [7:0] border_index_in,
	input wire logic pix_valid,
	input wire logic [7:0] pix_index,
	output logic [17:0] pix_color,
	output logic dac_idx_valid,
	output dcp_pkg::dcp_dac_idx_t dac_idx,
	output logic panel_valid,
	output dcp_pkg::dcp_panel_col_t panel_col
);
	import dcp_pkg::*;

	logic [15:0] cursor_q;
	logic [7:0] border_q;
	logic [8:0] pal_idx_q;
	logic [8:0] pal_idx_d;
	logic [2:0] mode_q;
	logic [17:0] pal_mem [PAL_ENTRIES];
	logic [15:0] dfifo_mem [DFIFO_WORDS];
	logic [15:0] cfifo_mem [CFIFO_WORDS];
	logic [FIFO_AW-1:0] dfifo_ptr_q;
	logic [FIFO_AW-1:0] cfifo_ptr_q;
	logic [17:0] pix_color_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic pal_acc;
	logic pal_wr_hit;

	function automatic logic idx_valid(input logic [8:0] idx);
		idx_valid = (idx <= PAL_OVERSCAN) && (idx != 9'h102)
			&& (idx != 9'h103);
	endfunction

	function automatic logic hit(input dcp_req_t r, input logic [15:0] off);
		hit = (r.addr == off);
	endfunction

	assign pal_acc = (req.wr || req.rd) && hit(req, OFF_PAL_DATA);
	assign pal_wr_hit = req.wr && hit(req, OFF_PAL_DATA)
		&& idx_valid(pal_idx_q);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cursor_q <= CURSOR_RESET;
		end else if (req.wr && hit(req, OFF_CURSOR_COLOR)) begin
			cursor_q <= req.wdata[15:0]; // [R3]
		end
	end

	// border index is supplied by the timing side, read-only here
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			border_q <= BORDER_RESET;
		end else begin
			border_q <= border_index_in; // [R7]
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mode_q <= 3'h0;
		end else if (req.wr && hit(req, OFF_DISP_MODE)) begin
			mode_q <= req.wdata[2:0];
		end
	end

	always_comb begin
		pal_idx_d = pal_idx_q;
		if (req.wr && hit(req, OFF_PAL_INDEX)) begin
			pal_idx_d = req.wdata[8:0];
		end else if (pal_acc) begin
			pal_idx_d = 9'(pal_idx_q + 9'h001); // [R11]
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pal_idx_q <= PAL_INDEX_RESET;
		end else begin
			pal_idx_q <= pal_idx_d;
		end
	end

	// palette storage: 256 standard plus extension entries
	always_ff @(posedge mclk) begin
		if (pal_wr_hit) begin
			pal_mem[pal_idx_q] <= req.wdata[17:0]; // [R8] [R12] [R13]
		end
	end

	// pixel lookup holds last colour while software writes
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pix_color_q <= ENTRY_RESET;
		end else if (pix_valid && !pal_wr_hit) begin
			pix_color_q <= pal_mem[{1'b0, pix_index}]; // [R14]
		end
	end
	assign pix_color = pix_color_q;

	// ram test ports: write stores low half at pointer, access steps it
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dfifo_ptr_q <= '0;
			cfifo_ptr_q <= '0;
		end else begin
			if ((req.wr || req.rd) && hit(req, OFF_DFIFO_TEST)) begin
				dfifo_ptr_q <= FIFO_AW'(dfifo_ptr_q + 1'b1); // [R10]
			end
			if ((req.wr || req.rd) && hit(req, OFF_CFIFO_TEST)) begin
				cfifo_ptr_q <= FIFO_AW'(cfifo_ptr_q + 1'b1); // [R10]
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (req.wr && hit(req, OFF_DFIFO_TEST)) begin
			dfifo_mem[dfifo_ptr_q] <= req.wdata[15:0]; // [R10]
		end
		if (req.wr && hit(req, OFF_CFIFO_TEST)) begin
			cfifo_mem[cfifo_ptr_q] <= req.wdata[15:0]; // [R10]
		end
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		case (req.addr)
			OFF_CURSOR_COLOR: rdata_d = {16'h0000, cursor_q};
			OFF_RSVD_COLOR: rdata_d = 32'h0000_0000; // [R6]
			OFF_BORDER_COLOR: rdata_d = {24'h000000, border_q}; // [R7]
			OFF_PAL_INDEX: rdata_d = {23'h000000, pal_idx_q};
			OFF_PAL_DATA: begin
				if (idx_valid(pal_idx_q)) begin
					rdata_d = {14'h0000, pal_mem[pal_idx_q]}; // [R15]
				end
			end
			OFF_DFIFO_TEST: rdata_d = {12'h000, dfifo_ptr_q,
				dfifo_mem[dfifo_ptr_q]};
			OFF_CFIFO_TEST: rdata_d = {12'h000, cfifo_ptr_q,
				cfifo_mem[cfifo_ptr_q]};
			OFF_DISP_MODE: rdata_d = {29'h0000_0000, mode_q};
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (req.rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end
	assign rdata = rdata_q;

	// external converter gets indices only in 8 bpp with that converter
	assign dac_idx_valid = mode_q[MODE_8BPP_BIT]
		&& mode_q[MODE_EXTDAC_BIT]; // [R1]
	assign dac_idx = '{cursor_first: cursor_q[7:0],
		cursor_second: cursor_q[15:8], border: border_q}; // [R1] [R3]

	assign panel_valid = mode_q[MODE_PANEL_BIT];
	assign panel_col = '{cursor_first: pal_mem[PAL_CURSOR0],
		cursor_second: pal_mem[PAL_CURSOR1],
		overscan: pal_mem[PAL_OVERSCAN]}; // [R2]

	property p_rsvd_zero;
		@(posedge mclk) disable iff (!reset_n)
		req.rd && hit(req, OFF_RSVD_COLOR) |=> rdata == 32'h0;
	endproperty
	a_reserved_word_zero: assert property (p_rsvd_zero) // [R6]
		else $error("reserved word read nonzero");

	a_border_read_value: assert property (@(posedge mclk)
		disable iff (!reset_n)
		req.rd && hit(req, OFF_BORDER_COLOR)
		|=> rdata == {24'h0, $past(border_q)}) // [R7]
		else $error("border read mismatch");

	a_border_read_only: assert property (@(posedge mclk)
		disable iff (!reset_n)
		req.wr && hit(req, OFF_BORDER_COLOR)
		|=> border_q == $past(border_index_in)) // [R7]
		else $error("border changed by write");

	sequence s_cursor_wr;
		req.wr && hit(req, OFF_CURSOR_COLOR);
	endsequence
	sequence s_cursor_rd;
		req.rd && hit(req, OFF_CURSOR_COLOR);
	endsequence
	a_cursor_write_read: assert property (@(posedge mclk)
		disable iff (!reset_n)
		s_cursor_wr ##1 s_cursor_rd
		|=> rdata == {16'h0, $past(req.wdata[15:0], 2)}) // [R3]
		else $error("cursor readback wrong");

	a_cursor_upper_zero: assert property (@(posedge mclk)
		disable iff (!reset_n)
		s_cursor_rd |=> rdata[31:16] == 16'h0) // [R3]
		else $error("cursor read upper bits set");

	sequence s_index_load;
		req.wr && hit(req, OFF_PAL_INDEX);
	endsequence
	a_index_load_value: assert property (@(posedge mclk)
		disable iff (!reset_n)
		s_index_load |=> pal_idx_q == $past(req.wdata[8:0])) // [R13]
		else $error("palette index load wrong");

	a_invalid_read_zero: assert property (@(posedge mclk)
		disable iff (!reset_n)
		req.rd && hit(req, OFF_PAL_DATA) && !idx_valid(pal_idx_q)
		|=> rdata == 32'h0) // [R13]
		else $error("invalid palette entry read nonzero");

	a_valid_read_data: assert property (@(posedge mclk)
		disable iff (!reset_n)
		req.rd && hit(req, OFF_PAL_DATA) && idx_valid(pal_idx_q)
		|=> rdata == {14'h0, $past(pal_mem[pal_idx_q])}) // [R15]
		else $error("palette read data wrong");

	a_palette_write_store: assert property (@(posedge mclk)
		disable iff (!reset_n)
		pal_wr_hit
		|=> pal_mem[$past(pal_idx_q)] == $past(req.wdata[17:0])) // [R12]
		else $error("palette entry not stored");

	a_rdata_idle_zero: assert property (@(posedge mclk)
		disable iff (!reset_n)
		!req.rd |=> rdata == 32'h0) // [R15]
		else $error("read data outside read slot");

	a_pix_lookup_value: assert property (@(posedge mclk)
		disable iff (!reset_n)
		pix_valid && !pal_wr_hit
		|=> pix_color == $past(pal_mem[{1'b0, pix_index}])) // [R8]
		else $error("pixel lookup colour wrong");

	a_cfifo_ptr_step: assert property (@(posedge mclk)
		disable iff (!reset_n)
		(req.wr || req.rd) && hit(req, OFF_CFIFO_TEST)
		|=> cfifo_ptr_q == FIFO_AW'($past(cfifo_ptr_q) + 1'b1)) // [R10]
		else $error("line buffer test pointer stuck");

	sequence s_pal_access;
		pal_acc && !(req.wr && hit(req, OFF_PAL_INDEX));
	endsequence
	a_index_auto_step: assert property (@(posedge mclk)
		disable iff (!reset_n)
		s_pal_access |=> pal_idx_q == 9'($past(pal_idx_q) + 9'h1)) // [R11]
		else $error("palette index did not advance");

	a_palette_read_width: assert property (@(posedge mclk)
		disable iff (!reset_n)
		req.rd |=> rdata[31:18] == 14'h0 || !$past(pal_acc)) // [R15]
		else $error("palette read upper bits set");

	a_dac_index_map: assert property (@(posedge mclk)
		disable iff (!reset_n)
		dac_idx_valid |-> dac_idx.cursor_second == cursor_q[15:8]
		&& dac_idx.border == border_q) // [R1]
		else $error("converter index mismatch");

	a_no_sparkle_hold: assert property (@(posedge mclk)
		disable iff (!reset_n)
		pal_wr_hit |=> $stable(pix_color)) // [R14]
		else $error("pixel colour changed during write");

	a_test_ptr_step: assert property (@(posedge mclk)
		disable iff (!reset_n)
		req.wr && hit(req, OFF_DFIFO_TEST)
		|=> dfifo_ptr_q == FIFO_AW'($past(dfifo_ptr_q) + 1'b1)) // [R10]
		else $error("display fifo test pointer stuck");
endmodule

// file: dv/dcp_dac_model.sv
// Purpose: external palette converter that takes cursor and border indices
// Assumes: indices are only meaningful while the index path is enabled
// Notes: holds the last indices received for the bench to inspect
module dcp_dac_model
	import dcp_pkg::*;
(
	input wire logic mclk,
	input wire logic idx_valid,
	input wire dcp_pkg::dcp_dac_idx_t idx,
	output dcp_pkg::dcp_dac_idx_t seen
);
	timeunit 1ns;
	timeprecision 1ns;
	// converter latches indices, never colour values
	always_ff @(posedge mclk) begin
		if (idx_valid) begin
			seen <= idx;
		end
	end
endmodule

// file: dv/dcp_regs_tb_top.sv
// Purpose: self-checking bench for the colour and palette registers
// Assumes: read data one cycle after the read strobe
// Notes: reads queue their expected word for the monitor
module dcp_regs_tb_top
	import dcp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0;
	logic reset_n = 0;
	logic pix_valid = 0;
	logic pend = 0;
	logic dac_valid, panel_valid;
	dcp_req_t req = '0;
	logic [31:0] rdata;
	logic [7:0] border_in = 8'h00;
	logic [7:0] pix_index = 8'h03;
	logic [17:0] pix_color;
	dcp_dac_idx_t dac_idx, seen;
	dcp_panel_col_t panel_col;
	logic [31:0] q[$];
	logic [17:0] d[6];
	logic [15:0] cur;
	logic [15:0] t[16];
	logic [15:0] ta;
	int seed = 69641;
	int fails = 0;
	int cmp_count = 0;

	always #10 mclk = ~mclk;

	dcp_regs dut(.mclk(mclk), .reset_n(reset_n), .req(req), .rdata(rdata),
		.border_index_in(border_in), .pix_valid(pix_valid),
		.pix_index(pix_index), .pix_color(pix_color),
		.dac_idx_valid(dac_valid), .dac_idx(dac_idx),
		.panel_valid(panel_valid), .panel_col(panel_col));
	dcp_dac_model dac(.mclk(mclk), .idx_valid(dac_valid), .idx(dac_idx),
		.seen(seen));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic op(input logic w, input logic r, input logic [15:0] a,
		input logic [31:0] dd, input logic pv);
		@(posedge mclk);
		req <= '{addr: a, wdata: dd, wr: w, rd: r};
		pix_valid <= pv;
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		q.push_back(e);
		op(1'b0, 1'b1, a, 32'h0, 1'b0);
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge mclk) begin
		if (pend) chk(rdata, q.pop_front());
		pend = req.rd;
	end

	initial begin
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		rd(OFF_CURSOR_COLOR, {16'h0, CURSOR_RESET});
		cur = $random(seed);
		border_in <= $random(seed);
		op(1, 0, OFF_CURSOR_COLOR, {16'h0, cur}, 0);
		rd(OFF_CURSOR_COLOR, {16'h0, cur});
		op(1, 0, OFF_RSVD_COLOR, 32'hffffffff, 0);
		op(1, 0, OFF_BORDER_COLOR, 32'h5a, 0);
		op(1, 0, OFF_DISP_MODE, 32'h3, 0);
		rd(OFF_CURSOR_COLOR, {16'h0, cur});
		rd(OFF_RSVD_COLOR, 32'h0);
		rd(OFF_BORDER_COLOR, {24'h0, border_in});
		rd(16'h8384, 32'h0);
		op(0, 0, 0, 0, 0);
		#1 chk({dac_valid, dac_idx},
			{1'b1, cur[7:0], cur[15:8], border_in});
		chk(seen, {cur[7:0], cur[15:8], border_in});
		op(1, 0, OFF_PAL_INDEX, 32'hff, 0);
		foreach (d[i]) begin
			d[i] = $random(seed);
			op(1, 0, OFF_PAL_DATA, {14'h0, d[i]}, 0);
		end
		rd(OFF_PAL_INDEX, 32'h105);
		op(1, 0, OFF_PAL_INDEX, 32'hff, 0);
		// entries 102h and 103h are reserved
		foreach (d[i]) begin
			rd(OFF_PAL_DATA,
				(i == 3 || i == 4) ? 32'h0 : {14'h0, d[i]});
		end
		op(1, 0, OFF_DISP_MODE, 32'h4, 0);
		op(0, 0, 0, 0, 0);
		#1 chk({panel_valid, panel_col}, {1'b1, d[1], d[2], d[5]});
		op(1, 0, OFF_PAL_INDEX, 32'h3, 0);
		op(1, 0, OFF_PAL_DATA, {14'h0, d[0]}, 0);
		op(0, 0, 0, 0, 1);
		op(1, 0, OFF_PAL_INDEX, 32'h3, 0);
		// lookup coincides with a palette write and must be dropped
		op(1, 0, OFF_PAL_DATA, {14'h0, d[1]}, 1);
		op(0, 0, 0, 0, 0);
		op(0, 0, 0, 0, 0);
		#1 chk(pix_color, d[0]);
		op(0, 0, 0, 0, 1);
		op(0, 0, 0, 0, 0);
		op(0, 0, 0, 0, 0);
		#1 chk(pix_color, d[1]);
		// fill all 16 test words so the pointer wraps to 0
		for (int j = 0; j < 2; j++) begin
			ta = (j == 0) ? OFF_DFIFO_TEST : OFF_CFIFO_TEST;
			foreach (t[k]) begin
				t[k] = $random(seed);
				op(1, 0, ta, {16'h0, t[k]}, 0);
			end
			rd(ta, {12'h0, 4'h0, t[0]});
			rd(ta, {12'h0, 4'h1, t[1]});
		end
		op(0, 0, 0, 0, 0);
		op(0, 0, 0, 0, 0);
		op(0, 0, 0, 0, 0);
		test_done;
	end

	initial begin
		repeat (3000) @(posedge mclk);
		fails++;
		test_done;
	end
endmodule
